// [design/csw_regs.sv]
`timescale 1ns/1ps
// ============================================================
// Compare-swap register group with ROM header and bus name
module csw_regs
   import csw_pkg::*;
#(
   parameter logic [3:0][DATA_W-1:0] RES_INIT = '0
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire csw_bus_t bus_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic serial_rom_present_i,
   input wire logic rom_load_valid_i,
   input wire logic [CRC_W-1:0] rom_crc_i,
   output logic [DATA_W-1:0] rom_header_o,
   output logic busy_o,
   output logic irq_o
);

   // ============================================================
   // Declarations
   csw_state_t s_q;
   csw_state_t s_d;
   csw_mem_req_t mem_req;
   logic [DATA_W-1:0] mem_rdata;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic ctrl_wr;
   logic start;
   logic match;
   logic rom_load;

   // Address decode shared by read and write paths
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Control word image, reserved bits zero
   function automatic logic [DATA_W-1:0] ctrl_word(input logic done, input logic [SEL_W-1:0] sel);
      ctrl_word = WORD_ZERO;
      ctrl_word[DONE_BIT] = done;
      ctrl_word[SEL_W-1:0] = sel;
   endfunction : ctrl_word

   // ============================================================
   // Strobes and compare
   assign ctrl_wr = bus_i.wr && hit(bus_i.addr, OFS_CONTROL);
   assign start = ctrl_wr && (s_q.phase == CSW_IDLE);
   assign match = (mem_rdata == s_q.expected);
   assign rom_load = serial_rom_present_i && rom_load_valid_i;

   // Resource port: selected word, written only on a match
   always_comb begin
      mem_req.idx = s_q.sel;
      mem_req.wdata = s_q.new_value;
      mem_req.we = (s_q.phase == CSW_DECIDE) && match;
   end

   // ============================================================
   // Next state
   always_comb begin
      s_d = s_q;
      // Register writes
      if (bus_i.wr) begin
         if (hit(bus_i.addr, OFS_NEW_VALUE)) begin
            s_d.new_value = bus_i.wdata;
         end
         if (hit(bus_i.addr, OFS_EXPECTED)) begin
            s_d.expected = bus_i.wdata;
         end
         if (hit(bus_i.addr, OFS_ROM_HEADER)) begin
            s_d.header = bus_i.wdata;
         end
      end
      // A control write drops the flag except in the decide cycle, where the set wins; select taken only when idle
      if (ctrl_wr) begin
         s_d.done = 1'b0;
      end
      if (start) begin
         s_d.sel = bus_i.wdata[SEL_W-1:0];
      end
      // Serial ROM preload of the check value wins over a host write
      if (rom_load) begin
         s_d.header[CRC_W-1:0] = rom_crc_i;
      end
      // Swap sequence
      case (s_q.phase)
         CSW_IDLE: begin
            if (start) begin
               s_d.phase = CSW_FETCH;
            end
         end
         CSW_FETCH: begin
            s_d.phase = CSW_DECIDE;
         end
         CSW_DECIDE: begin
            s_d.phase = CSW_IDLE;
            s_d.new_value = mem_rdata; // Old value returned to software
            s_d.done = 1'b1;
         end
         default: begin
            s_d.phase = CSW_IDLE;
         end
      endcase
      // Read data for the next cycle
      s_d.rdata = WORD_ZERO;
      if (bus_i.rd) begin
         case (bus_i.addr)
            OFS_NEW_VALUE: s_d.rdata = s_q.new_value;
            OFS_EXPECTED: s_d.rdata = s_q.expected;
            OFS_CONTROL: s_d.rdata = ctrl_word(s_q.done, s_q.sel);
            OFS_ROM_HEADER: s_d.rdata = s_q.header;
            OFS_BUS_NAME: s_d.rdata = BUS_NAME_VAL;
            OFS_IRQ_STATUS: s_d.rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
            OFS_IRQ_MASK: s_d.rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
            default: s_d.rdata = WORD_ZERO;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_q.phase <= CSW_IDLE;
         s_q.done <= DONE_RESET;
         s_q.sel <= RES_BUS_MANAGER_ID;
         s_q.new_value <= WORD_ZERO;
         s_q.expected <= WORD_ZERO;
         s_q.header <= HDR_RESET;
         s_q.rdata <= WORD_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   // ============================================================
   // Outputs
   assign rdata_o = s_q.rdata;
   assign rom_header_o = s_q.header;
   assign busy_o = (s_q.phase != CSW_IDLE);

   // Interrupt events
   always_comb begin
      irq_event = '0;
      irq_event[IRQ_SWAP_DONE] = (s_q.phase == CSW_DECIDE);
      irq_event[IRQ_ROM_LOADED] = rom_load;
   end

   // ============================================================
   // Submodules
   csw_res_mem #(
      .RES_INIT(RES_INIT)
   ) u_mem (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .req_i(mem_req),
      .rdata_o(mem_rdata)
   );

   csw_irq u_irq (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .event_i(irq_event),
      .status_rd_i(bus_i.rd && hit(bus_i.addr, OFS_IRQ_STATUS)),
      .mask_wr_i(bus_i.wr && hit(bus_i.addr, OFS_IRQ_MASK)),
      .mask_wdata_i(bus_i.wdata[IRQ_W-1:0]),
      .status_o(irq_status),
      .mask_o(irq_mask),
      .irq_o(irq_o)
   );

   // ============================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_start;
      start;
   endsequence

   sequence s_finish;
      (s_q.phase == CSW_FETCH) ##1 (s_q.phase == CSW_DECIDE) ##1 (s_q.phase == CSW_IDLE);
   endsequence

   chk_swap_runs_through: assert property (s_start |=> s_finish)
      else $error("swap sequence did not run");

   chk_done_after_swap: assert property (s_start ##1 s_finish |-> s_q.done)
      else $error("completion flag not set");

   chk_write_only_match: assert property ((s_q.phase == CSW_DECIDE) |->
      (mem_req.we == (mem_rdata == s_q.expected)))
      else $error("resource write does not follow compare");

   chk_no_write_outside: assert property ((s_q.phase != CSW_DECIDE) |-> !mem_req.we)
      else $error("resource written outside decide");

   chk_ctrl_write_clears: assert property ((ctrl_wr && s_q.phase != CSW_DECIDE) |=> !s_q.done)
      else $error("control write did not clear flag");

   chk_select_target: assert property (start |=> mem_req.idx == $past(bus_i.wdata[SEL_W-1:0]))
      else $error("wrong resource selected");

   chk_reserved_zero: assert property ((bus_i.rd && hit(bus_i.addr, OFS_CONTROL)) |=>
      (rdata_o[DONE_BIT-1:SEL_W] == '0))
      else $error("reserved control bits not zero");

   chk_bus_name_const: assert property ((bus_i.rd && hit(bus_i.addr, OFS_BUS_NAME)) |=>
      (rdata_o == BUS_NAME_VAL))
      else $error("bus name quadlet wrong");

   chk_rom_crc_load: assert property (rom_load |=>
      (rom_header_o[CRC_W-1:0] == $past(rom_crc_i)))
      else $error("check value not loaded");

   chk_header_mirror: assert property ((bus_i.wr && hit(bus_i.addr, OFS_ROM_HEADER) && !rom_load) |=>
      (rom_header_o == $past(bus_i.wdata)))
      else $error("header quadlet not presented");

   // ============================================================
   // Sequencer checks

   // The one cycle that may touch a resource
   sequence s_decide;
      (s_q.phase == CSW_DECIDE);
   endsequence

   // Control write that lands on a running swap
   sequence s_busy_ctrl_wr;
      ctrl_wr && (s_q.phase != CSW_IDLE);
   endsequence

   // Serial ROM load of the check value
   sequence s_rom_load;
      rom_load;
   endsequence

   // No start, no movement
   chk_idle_holds: assert property ((s_q.phase == CSW_IDLE) && !start |=>
      (s_q.phase == CSW_IDLE))
      else $error("sequencer left idle without a start");

   // A running swap is neither restarted nor reselected
   chk_busy_no_restart: assert property (s_busy_ctrl_wr |=> (s_q.phase != CSW_FETCH))
      else $error("control write restarted a swap");

   chk_busy_keeps_sel: assert property (s_busy_ctrl_wr |=> (s_q.sel == $past(s_q.sel)))
      else $error("select changed during a swap");

   // Old resource value handed back in the new value register
   chk_old_value_back: assert property (s_decide |=> (s_q.new_value == $past(mem_rdata)))
      else $error("old resource value not returned");

   // Completion raises its sticky status bit
   chk_swap_irq_event: assert property (s_decide |=> irq_status[IRQ_SWAP_DONE])
      else $error("swap completion event lost");

   // Decide cycle sets the flag even beside a control write
   chk_set_beats_clear: assert property (s_decide |=> s_q.done)
      else $error("completion flag lost to a control write");

   // ============================================================
   // Register path checks

   // Reads answer for one cycle, zero otherwise
   chk_rdata_idle_zero: assert property (!bus_i.rd |=> (rdata_o == WORD_ZERO))
      else $error("read data outside a read cycle");

   // Control image carries the flag and the select
   chk_ctrl_image: assert property ((bus_i.rd && hit(bus_i.addr, OFS_CONTROL)) |=>
      (rdata_o[DONE_BIT] == $past(s_q.done)) && (rdata_o[SEL_W-1:0] == $past(s_q.sel)))
      else $error("control image wrong");

   // Compare and new value words take host writes
   chk_expected_write: assert property ((bus_i.wr && hit(bus_i.addr, OFS_EXPECTED)) |=>
      (s_q.expected == $past(bus_i.wdata)))
      else $error("expected value not written");

   chk_new_value_write: assert property ((bus_i.wr && hit(bus_i.addr, OFS_NEW_VALUE) &&
      (s_q.phase != CSW_DECIDE)) |=> (s_q.new_value == $past(bus_i.wdata)))
      else $error("new value not written");

   // Header moves only by host write or ROM load
   chk_header_steady: assert property ((!rom_load && !(bus_i.wr && hit(bus_i.addr, OFS_ROM_HEADER))) |=>
      $stable(rom_header_o))
      else $error("header changed without cause");

   // Absent serial ROM leaves the check value alone
   chk_no_rom_no_load: assert property ((rom_load_valid_i && !serial_rom_present_i &&
      !(bus_i.wr && hit(bus_i.addr, OFS_ROM_HEADER))) |=> $stable(rom_header_o))
      else $error("check value loaded without serial ROM");

   // ROM load raises its sticky status bit
   chk_rom_irq_event: assert property (s_rom_load |=> irq_status[IRQ_ROM_LOADED])
      else $error("ROM load event lost");

   // Mask register takes host writes
   chk_mask_write: assert property ((bus_i.wr && hit(bus_i.addr, OFS_IRQ_MASK)) |=>
      (irq_mask == $past(bus_i.wdata[IRQ_W-1:0])))
      else $error("mask not written");

endmodule : csw_regs

// [inc/csw_pkg.sv]
// ============================================================
// How it works
// - Host-started compare-swap runs on the selected bus management resource.
// - Resource takes the new value only when the compare matches.
// - Expected value is compared with the current resource contents.
// - Bit 31 of swap control sets when a compare-swap finishes.
// - A write to swap control clears the completion flag, except in the decide cycle, where the flag sets.
// - Select 00 manager id, 01 bandwidth, 10 channels hi, 11 channels lo.
// - Swap control bits 30 to 2 ignore writes and read zero.
// - ROM header register supplies the first configuration ROM quadlet.
// - Header check value loads from serial ROM when one is present.
// - Bus name quadlet is read-only constant 3133_3934h.
package csw_pkg;

   // ============================================================
   // Register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_NEW_VALUE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_EXPECTED = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_ROM_HEADER = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_BUS_NAME = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h44;

   // ============================================================
   // Fields and reset values
   localparam int DONE_BIT = 31;
   localparam int SEL_W = 2;
   localparam int CRC_W = 16;
   localparam logic [DATA_W-1:0] BUS_NAME_VAL = 32'h3133_3934;
   localparam logic [DATA_W-1:0] HDR_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic DONE_RESET = 1'b1;
   localparam int IRQ_W = 2;
   localparam int IRQ_SWAP_DONE = 0;
   localparam int IRQ_ROM_LOADED = 1;

   // ============================================================
   // Types
   typedef enum logic [1:0] {
      CSW_IDLE = 2'b00,
      CSW_FETCH = 2'b01,
      CSW_DECIDE = 2'b10
   } csw_phase_t;

   typedef enum logic [1:0] {
      RES_BUS_MANAGER_ID = 2'b00,
      RES_BANDWIDTH_AVAILABLE = 2'b01,
      RES_CHANNELS_AVAILABLE_HI = 2'b10,
      RES_CHANNELS_AVAILABLE_LO = 2'b11
   } csw_res_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } csw_bus_t;

   typedef struct packed {
      logic we;
      logic [SEL_W-1:0] idx;
      logic [DATA_W-1:0] wdata;
   } csw_mem_req_t;

   typedef struct packed {
      csw_phase_t phase;
      logic done;
      logic [SEL_W-1:0] sel;
      logic [DATA_W-1:0] new_value;
      logic [DATA_W-1:0] expected;
      logic [DATA_W-1:0] header;
      logic [DATA_W-1:0] rdata;
   } csw_state_t;

endpackage : csw_pkg

// [design/csw_res_mem.sv]
`timescale 1ns/1ps
// ============================================================
// Four bus management resource words, registered read
module csw_res_mem
   import csw_pkg::*;
#(
   parameter logic [3:0][DATA_W-1:0] RES_INIT = '0
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire csw_mem_req_t req_i,
   output logic [DATA_W-1:0] rdata_o
);

   typedef struct packed {
      logic [3:0][DATA_W-1:0] words;
      logic [DATA_W-1:0] rdata;
   } csw_mem_state_t;

   csw_mem_state_t s_q;
   csw_mem_state_t s_d;

   // Read old contents, then write
   always_comb begin
      s_d = s_q;
      s_d.rdata = s_q.words[req_i.idx];
      if (req_i.we) begin
         s_d.words[req_i.idx] = req_i.wdata;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_q <= {RES_INIT, WORD_ZERO};
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;

   chk_mem_write_lands: assert property (@(posedge clk_i) disable iff (srst_i)
      req_i.we |=> s_q.words[$past(req_i.idx)] == $past(req_i.wdata))
      else $error("resource write not stored");

endmodule : csw_res_mem

// [design/csw_irq.sv]
`timescale 1ns/1ps
// ============================================================
// Sticky event status, mask, one level interrupt
module csw_irq
   import csw_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [IRQ_W-1:0] event_i,
   input wire logic status_rd_i,
   input wire logic mask_wr_i,
   input wire logic [IRQ_W-1:0] mask_wdata_i,
   output logic [IRQ_W-1:0] status_o,
   output logic [IRQ_W-1:0] mask_o,
   output logic irq_o
);

   typedef struct packed {
      logic [IRQ_W-1:0] status;
      logic [IRQ_W-1:0] mask;
   } csw_irq_state_t;

   csw_irq_state_t s_q;
   csw_irq_state_t s_d;

   // Read clears, a new event wins
   always_comb begin
      s_d = s_q;
      if (status_rd_i) begin
         s_d.status = '0;
      end
      s_d.status = s_d.status | event_i;
      if (mask_wr_i) begin
         s_d.mask = mask_wdata_i;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign status_o = s_q.status;
   assign mask_o = s_q.mask;
   assign irq_o = |(s_q.status & s_q.mask);

   chk_irq_event_kept: assert property (@(posedge clk_i) disable iff (srst_i)
      (|event_i) |=> ((status_o & $past(event_i)) == $past(event_i)))
      else $error("event lost from status");

endmodule : csw_irq

// [test/swap_expected_value_swap_rom_header_bench.sv]
`timescale 1ns/1ps
// ============================================================
// Compare with count, report at once
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch at %0t: got %h want %h", $time, g, e); end end

module swap_expected_value_swap_rom_header_bench;
   import csw_pkg::*;

   // ============================================================
   // Stimulus and observed signals
   localparam logic [3:0][DATA_W-1:0] INIT = {32'h4444_0003, 32'h3333_0002, 32'h2222_0001, 32'h1111_0000};
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   csw_bus_t bus = '0;
   logic serial_rom_present = 1'b0;
   logic load_valid = 1'b0;
   logic [CRC_W-1:0] crc = 16'h0000;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] rom_header;
   logic busy;
   logic irq;
   logic [DATA_W-1:0] d;
   logic [DATA_W-1:0] res_model [4] = '{32'h1111_0000, 32'h2222_0001, 32'h3333_0002, 32'h4444_0003};
   int mismatches = 0;
   int total_checks = 0;

   // ============================================================
   // Clock and design
   always #12.5 clk_i = ~clk_i;

   csw_regs #(.RES_INIT(INIT)) uut (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .bus_i(bus),
      .rdata_o(rdata),
      .serial_rom_present_i(serial_rom_present),
      .rom_load_valid_i(load_valid),
      .rom_crc_i(crc),
      .rom_header_o(rom_header),
      .busy_o(busy),
      .irq_o(irq)
   );

   // ============================================================
   // Bus tasks
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk_i);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= v;
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk_i);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge clk_i);
      bus.rd <= 1'b0;
      @(negedge clk_i);
      v = rdata;
   endtask : rd

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // Full compare-swap; reserved control bits written as ones
   task automatic swap(input logic [1:0] sel, input logic [DATA_W-1:0] expv, input logic [DATA_W-1:0] newv,
                       output logic [DATA_W-1:0] old);
      logic [DATA_W-1:0] c;
      int n;
      wr(OFS_EXPECTED, expv);
      wr(OFS_NEW_VALUE, newv);
      wr(OFS_CONTROL, {30'h3FFF_FFFF, sel});
      @(negedge clk_i);
      `CHK(busy, 1'b1)
      rd(OFS_CONTROL, c);
      `CHK(c[DONE_BIT], 1'b0)
      n = 0;
      while (c[DONE_BIT] !== 1'b1) begin
         n++;
         if (n > 20) begin
            mismatches++;
            $display("mismatch at %0t: swap did not complete", $time);
            end_of_test();
         end
         rd(OFS_CONTROL, c);
      end
      `CHK(c, {30'h2000_0000, sel})
      `CHK(busy, 1'b0)
      rd(OFS_NEW_VALUE, old);
   endtask : swap

   // ============================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      srst_i <= 1'b0;
      // Reset values, constant and unmapped places
      rd(OFS_CONTROL, d);
      `CHK(d, 32'h8000_0000)
      rd(OFS_BUS_NAME, d);
      `CHK(d, 32'h3133_3934)
      wr(OFS_BUS_NAME, 32'h0000_0000);
      rd(OFS_BUS_NAME, d);
      `CHK(d, 32'h3133_3934)
      rd(8'h30, d);
      `CHK(d, 32'h0000_0000)
      `CHK(irq, 1'b0)
      // Header written by software, then serial ROM load
      wr(OFS_ROM_HEADER, 32'h0102_0304);
      rd(OFS_ROM_HEADER, d);
      `CHK(d, 32'h0102_0304)
      @(posedge clk_i);
      load_valid <= 1'b1;
      crc <= 16'hBEEF;
      @(posedge clk_i);
      load_valid <= 1'b0;
      @(negedge clk_i);
      `CHK(rom_header, 32'h0102_0304)
      @(posedge clk_i);
      serial_rom_present <= 1'b1;
      load_valid <= 1'b1;
      @(posedge clk_i);
      load_valid <= 1'b0;
      @(negedge clk_i);
      `CHK(rom_header, 32'h0102_BEEF)
      rd(OFS_IRQ_STATUS, d);
      `CHK(d, 32'h0000_0002)
      // Failing, passing and read-out swap on every resource
      for (int i = 0; i < 4; i++) begin
         swap(2'(i), res_model[i] ^ 32'h0000_0100, 32'hDEAD_0000, d);
         `CHK(d, res_model[i])
         swap(2'(i), res_model[i], res_model[i] ^ 32'hFFFF_0000, d);
         `CHK(d, res_model[i])
         res_model[i] = res_model[i] ^ 32'hFFFF_0000;
         swap(2'(i), 32'h0000_0000, 32'h0000_0000, d);
         `CHK(d, res_model[i])
      end
      // Control write landing in the decide cycle: flag set wins, select kept
      wr(OFS_EXPECTED, res_model[1] ^ 32'h0000_0001);
      wr(OFS_CONTROL, 32'h0000_0001);
      wr(OFS_CONTROL, 32'h0000_0002);
      rd(OFS_CONTROL, d);
      `CHK(d, 32'h8000_0001)
      rd(OFS_NEW_VALUE, d);
      `CHK(d, res_model[1])
      // Completion event masked, unmasked, cleared by read
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      @(negedge clk_i);
      `CHK(irq, 1'b1)
      rd(OFS_IRQ_STATUS, d);
      `CHK(d, 32'h0000_0001)
      `CHK(irq, 1'b0)
      rd(OFS_IRQ_MASK, d);
      `CHK(d, 32'h0000_0001)
      // Second reset in mid-run
      @(posedge clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(OFS_CONTROL, d);
      `CHK(d, 32'h8000_0000)
      rd(OFS_ROM_HEADER, d);
      `CHK(d, 32'h0000_0000)
      swap(2'b00, 32'h0000_0000, 32'h0000_0000, d);
      `CHK(d, 32'h1111_0000)
      end_of_test();
   end

endmodule : swap_expected_value_swap_rom_header_bench
